// file: sarc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R01: Completion sets status bit 0
// R02: Result read clears status bit 0
// R03: Result sits in bits 27:16
// R04: Soft reset bit 0 restores defaults
// R05: Acquire: balance closed, switches sampling
// R06: Convert: balance open, switches converting
// R07: Done when search rebalances comparator
// R08: Pseudo: negative channel then reference
// R09: Single-ended: negative side grounded
// R10: Channel code 0x10 selects temperature sensor
// R11: Software powers up, waits, starts continuous
// R12: Reference bit 0 drives reference pin
// R13: DAC runs only with reference enabled
// R14: Single software conversion clears type field
// R15: Mode 00 single, 01 diff, 10 pseudo
// R16: Twelve steps, MSB first, one bit each
module sarc_ctrl
   import sarc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata,
   input  wire logic                external_convert_pin,
   input  wire logic                timer_trigger,
   input  wire logic                cmp_high,
   output logic [RES_BITS-1:0]      dac_trial,
   output logic                     comparator_balance_switch,
   output logic                     positive_input_switch,
   output logic [1:0]               negative_input_switch,
   output logic [4:0]               mux_pos_chan,
   output logic [4:0]               mux_neg_chan,
   output logic                     temp_sensor_sel,
   output logic                     adc_powered,
   output logic                     ref_pin_enable,
   output logic                     dac_enable,
   output logic                     irq
);
   typedef enum logic [1:0] {SARC_IDLE, SARC_ACQ, SARC_CONV} sarc_state_t;

   sarc_bus_t   bus;
   logic        pin_s;
   logic        pin_prev_r, pin_prev_nxt;
   logic        start_req;
   logic        srch_start;
   logic        srch_done;
   logic [RES_BITS-1:0] srch_code;
   logic [RES_BITS-1:0] srch_trial;

   logic [7:0]  control_r, control_nxt;
   logic [4:0]  pos_chan_r, pos_chan_nxt;
   logic [4:0]  neg_chan_r, neg_chan_nxt;
   logic        status_r, status_nxt;
   logic [11:0] result_r, result_nxt;
   logic [7:0]  ref_r, ref_nxt;
   logic        irq_stat_r, irq_stat_nxt;
   logic        irq_mask_r, irq_mask_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   sarc_state_t state_r, state_nxt;
   logic [4:0]  acq_cnt_r, acq_cnt_nxt;
   sarc_sw_t    sw_r, sw_nxt;
   logic        irq_r, dac_en_r;
   logic        soft_rst;

   assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
   assign soft_rst = bus.wr && bus.addr == OFF_SOFT_RST && bus.wdata[0];

   // Pin is asynchronous to clk
   sarc_sync u_pin_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       (external_convert_pin),
      .q       (pin_s)
   );

   sarc_search u_search
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .start    (srch_start),
      .cmp_high (cmp_high),
      .trial    (srch_trial),
      .done     (srch_done),
      .code     (srch_code)
   );

   // Conversion trigger select from the type field
   always_comb
   begin
      pin_prev_nxt = pin_s;
      start_req    = 1'b0;
      if (control_r[CTL_ENABLE_BIT] && control_r[CTL_POWER_BIT])
      begin
         case (control_r[2:0])
            TYPE_PIN:    start_req = pin_s && !pin_prev_r;
            3'h1, 3'h2:  start_req = timer_trigger;
            TYPE_SINGLE: start_req = 1'b1;
            TYPE_CONT:   start_req = 1'b1;
            default:     start_req = 1'b0;
         endcase
      end
   end

   // Switch positions per mode; reserved mode treated as single-ended
   function automatic sarc_sw_t sw_for(input logic conv, input logic [1:0] mode);
      sarc_sw_t s;
      s.balance_closed = !conv;                                    // R05 R06
      s.pos_sw_b       = conv;                                     // R05 R06
      case (mode)
         MODE_DIFF:   s.neg_sel = SARC_NEG_CHAN;                   // R15
         MODE_PSEUDO: s.neg_sel = conv ? SARC_NEG_REF : SARC_NEG_CHAN; // R08
         default:     s.neg_sel = SARC_NEG_GND;                    // R09
      endcase
      return s;
   endfunction : sw_for

   // Sequencer: acquisition time, then a twelve step search
   always_comb
   begin
      state_nxt   = state_r;
      acq_cnt_nxt = acq_cnt_r;
      srch_start  = 1'b0;
      case (state_r)
         SARC_IDLE:
         begin
            if (start_req)
            begin
               state_nxt   = SARC_ACQ;
               acq_cnt_nxt = ACQ_CNT;
            end
         end
         SARC_ACQ:
         begin
            if (acq_cnt_r == 5'h00)
            begin
               state_nxt  = SARC_CONV;
               srch_start = 1'b1;
            end
            else
               acq_cnt_nxt = acq_cnt_r - 5'h01;
         end
         SARC_CONV:
            if (srch_done)
               state_nxt = SARC_IDLE; // R07
         default:
            state_nxt = SARC_IDLE;
      endcase
      if (soft_rst || !control_r[CTL_POWER_BIT])
         state_nxt = SARC_IDLE;
      sw_nxt = sw_for(state_nxt == SARC_CONV, control_nxt[4:3]); // Next mode keeps switches in step with the register
   end

   // Register file next values; a conversion finish beats a clearing read
   always_comb
   begin
      control_nxt  = control_r;
      pos_chan_nxt = pos_chan_r;
      neg_chan_nxt = neg_chan_r;
      status_nxt   = status_r;
      result_nxt   = result_r;
      ref_nxt      = ref_r;
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      rdata_nxt    = 32'h00000000;
      if (bus.wr)
      begin
         case (bus.addr)
            OFF_CONTROL:  control_nxt  = bus.wdata[7:0];
            OFF_POS_CHAN: pos_chan_nxt = bus.wdata[4:0];
            OFF_NEG_CHAN: neg_chan_nxt = bus.wdata[4:0];
            OFF_REF_CTRL: ref_nxt      = {7'h00, bus.wdata[0]}; // R12
            OFF_IRQ_STAT: if (bus.wdata[0]) irq_stat_nxt = 1'b0;
            OFF_IRQ_MASK: irq_mask_nxt = bus.wdata[0];
            default:      ;
         endcase
      end
      if (bus.rd)
      begin
         case (bus.addr)
            OFF_CONTROL:  rdata_nxt = {24'h000000, control_r};
            OFF_POS_CHAN: rdata_nxt = {27'h0000000, pos_chan_r};
            OFF_NEG_CHAN: rdata_nxt = {27'h0000000, neg_chan_r};
            OFF_STATUS:   rdata_nxt = {31'h00000000, status_r};
            OFF_RESULT:
            begin
               rdata_nxt  = {4'h0, result_r, 16'h0000}; // R03
               status_nxt = 1'b0;                       // R02
            end
            OFF_REF_CTRL: rdata_nxt = {24'h000000, ref_r};
            OFF_IRQ_STAT: rdata_nxt = {31'h00000000, irq_stat_r};
            OFF_IRQ_MASK: rdata_nxt = {31'h00000000, irq_mask_r};
            default:      rdata_nxt = 32'h00000000;
         endcase
      end
      if (srch_done && state_r == SARC_CONV)
      begin
         result_nxt   = srch_code;
         status_nxt   = 1'b1; // R01
         irq_stat_nxt = 1'b1;
         if (control_r[2:0] == TYPE_SINGLE && !(bus.wr && bus.addr == OFF_CONTROL))
            control_nxt[2:0] = TYPE_PIN; // R14
      end
      if (soft_rst)
      begin
         control_nxt  = CONTROL_RST; // R04
         pos_chan_nxt = CHAN_RST;
         neg_chan_nxt = CHAN_RST;
         status_nxt   = 1'b0;
         result_nxt   = RESULT_RST;
         ref_nxt      = REF_RST;
         irq_stat_nxt = 1'b0;
         irq_mask_nxt = 1'b0;
      end
   end

   // All state registers but the output flops below
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         control_r  <= CONTROL_RST;
         pos_chan_r <= CHAN_RST;
         neg_chan_r <= CHAN_RST;
         status_r   <= 1'b0;
         result_r   <= RESULT_RST;
         ref_r      <= REF_RST;
         irq_stat_r <= 1'b0;
         irq_mask_r <= 1'b0;
         rdata_r    <= 32'h00000000;
         state_r    <= SARC_IDLE;
         acq_cnt_r  <= 5'h00;
         sw_r       <= '{balance_closed: 1'b1, pos_sw_b: 1'b0, neg_sel: SARC_NEG_GND};
         pin_prev_r <= 1'b0;
         irq_r      <= 1'b0;
         dac_en_r   <= 1'b0;
      end
      else
      begin
         control_r  <= control_nxt;
         pos_chan_r <= pos_chan_nxt;
         neg_chan_r <= neg_chan_nxt;
         status_r   <= status_nxt;
         result_r   <= result_nxt;
         ref_r      <= ref_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         rdata_r    <= rdata_nxt;
         state_r    <= state_nxt;
         acq_cnt_r  <= acq_cnt_nxt;
         sw_r       <= sw_nxt;
         pin_prev_r <= pin_prev_nxt;
         irq_r      <= irq_stat_nxt & irq_mask_nxt;
         dac_en_r   <= ref_nxt[0]; // R13
      end
   end

   // Outputs; mux codes pass through a register so they settle with the switches
   logic [4:0] mux_pos_r, mux_neg_r;
   logic       temp_r, pwr_r;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mux_pos_r <= CHAN_RST;
         mux_neg_r <= CHAN_RST;
         temp_r    <= 1'b0;
         pwr_r     <= 1'b0;
      end
      else
      begin
         mux_pos_r <= pos_chan_nxt;
         mux_neg_r <= neg_chan_nxt;
         temp_r    <= (pos_chan_nxt == CHAN_TEMP); // R10
         pwr_r     <= control_nxt[CTL_POWER_BIT];
      end
   end

   assign reg_rdata                 = rdata_r;
   assign comparator_balance_switch = sw_r.balance_closed;
   assign positive_input_switch     = sw_r.pos_sw_b;
   assign negative_input_switch     = sw_r.neg_sel;
   assign mux_pos_chan              = mux_pos_r;
   assign mux_neg_chan              = mux_neg_r;
   assign temp_sensor_sel           = temp_r;
   assign adc_powered               = pwr_r;
   assign ref_pin_enable            = ref_r[0]; // R12
   assign dac_enable                = dac_en_r;
   assign irq                       = irq_r;
   assign dac_trial                 = srch_trial; // Already a flop inside the search

   a_done_sets_flag: assert property (@(posedge clk) disable iff (sys_rst) // R01
      (srch_done && state_r == SARC_CONV && !soft_rst) |=> status_r && result_r == $past(srch_code))
      else $error("completion did not set status");
   a_read_clears_flag: assert property (@(posedge clk) disable iff (sys_rst) // R02
      (bus.rd && bus.addr == OFF_RESULT && !srch_done) |=> !status_r)
      else $error("result read did not clear status");
   a_result_place: assert property (@(posedge clk) disable iff (sys_rst) // R03
      (bus.rd && bus.addr == OFF_RESULT) |=> reg_rdata == {4'h0, $past(result_r), 16'h0000})
      else $error("result misplaced");
   a_soft_reset: assert property (@(posedge clk) disable iff (sys_rst) // R04
      soft_rst |=> control_r == CONTROL_RST && ref_r == REF_RST && !status_r)
      else $error("soft reset left state");
   a_acq_switch: assert property (@(posedge clk) disable iff (sys_rst) // R05
      (state_r == SARC_ACQ) |-> comparator_balance_switch && !positive_input_switch)
      else $error("switches wrong in acquisition");
   a_conv_switch: assert property (@(posedge clk) disable iff (sys_rst) // R06
      (state_r == SARC_CONV) |-> !comparator_balance_switch && positive_input_switch)
      else $error("switches wrong in conversion");
   a_conv_length: assert property (@(posedge clk) disable iff (sys_rst) // R16
      (srch_done && state_r == SARC_CONV) |-> $past(state_r, 12) == SARC_CONV && $past(state_r, 13) == SARC_ACQ)
      else $error("conversion not twelve steps long");
   a_pseudo_ref: assert property (@(posedge clk) disable iff (sys_rst) // R08
      (state_r == SARC_CONV && control_r[4:3] == MODE_PSEUDO) |-> negative_input_switch == SARC_NEG_REF)
      else $error("pseudo mode not on reference");
   a_single_gnd: assert property (@(posedge clk) disable iff (sys_rst) // R09
      (state_r != SARC_IDLE && control_r[4:3] == MODE_SINGLE) |-> negative_input_switch == SARC_NEG_GND)
      else $error("single-ended not grounded");
   a_single_type: assert property (@(posedge clk) disable iff (sys_rst) // R14
      (srch_done && state_r == SARC_CONV && control_r[2:0] == TYPE_SINGLE && !bus.wr) |=> control_r[2:0] == TYPE_PIN)
      else $error("single type not cleared");
   a_dac_gate: assert property (@(posedge clk) disable iff (sys_rst) // R13
      dac_enable |-> ref_pin_enable)
      else $error("dac on without reference");
   // Switch and register checks that the bench also reaches directly
   a_diff_chan: assert property (@(posedge clk) disable iff (sys_rst) // R15
      (state_r != SARC_IDLE && control_r[4:3] == MODE_DIFF) |-> negative_input_switch == SARC_NEG_CHAN)
      else $error("differential mode not on channel");
   a_ref_pin: assert property (@(posedge clk) disable iff (sys_rst) // R12
      (bus.wr && bus.addr == OFF_REF_CTRL) |=> ref_pin_enable == $past(bus.wdata[0]))
      else $error("reference pin not following control bit");
   a_temp_sel: assert property (@(posedge clk) disable iff (sys_rst) // R10
      (bus.wr && bus.addr == OFF_POS_CHAN) |=> temp_sensor_sel == ($past(bus.wdata[4:0]) == CHAN_TEMP))
      else $error("temperature channel select wrong");
endmodule : sarc_ctrl
`default_nettype wire

// file: sarc_pkg.sv
package sarc_pkg;
   // Register byte offsets on the plain register port
   localparam logic [7:0] OFF_CONTROL   = 8'h00;
   localparam logic [7:0] OFF_POS_CHAN  = 8'h04;
   localparam logic [7:0] OFF_NEG_CHAN  = 8'h08;
   localparam logic [7:0] OFF_STATUS    = 8'h0C;
   localparam logic [7:0] OFF_RESULT    = 8'h10;
   localparam logic [7:0] OFF_SOFT_RST  = 8'h14;
   localparam logic [7:0] OFF_REF_CTRL  = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h1C;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;

   // Control register fields and result placement
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_POWER_BIT  = 5;
   localparam int CTL_MODE_LSB   = 3;
   localparam int CTL_TYPE_LSB   = 0;
   localparam int RES_LSB        = 16;
   localparam int RES_BITS       = 12;

   // Reset values
   localparam logic [7:0] CONTROL_RST  = 8'h00;
   localparam logic [4:0] CHAN_RST     = 5'h00;
   localparam logic [7:0] REF_RST      = 8'h00;
   localparam logic [11:0] RESULT_RST  = 12'h000;

   // Mode, trigger and temperature channel codes
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_DIFF   = 2'h1;
   localparam logic [1:0] MODE_PSEUDO = 2'h2;
   localparam logic [2:0] TYPE_PIN    = 3'h0;
   localparam logic [2:0] TYPE_SINGLE = 3'h3;
   localparam logic [2:0] TYPE_CONT   = 3'h4;
   localparam logic [4:0] CHAN_TEMP   = 5'h10;

   // Timing
   localparam int CLK_MHZ      = 100;
   localparam int ACQ_NS       = 200;
   localparam int ACQ_CYCLES   = (ACQ_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0] ACQ_CNT = 5'(ACQ_CYCLES);

   // Analog switch positions: positive input 0 = sampling (A), 1 = conversion (B); balance switch closed (1) while sampling
   typedef enum logic [1:0] {SARC_NEG_CHAN, SARC_NEG_GND, SARC_NEG_REF} sarc_neg_t;
   typedef struct packed {
      logic      balance_closed;
      logic      pos_sw_b;
      sarc_neg_t neg_sel;
   } sarc_sw_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } sarc_bus_t;
endpackage : sarc_pkg

// file: sarc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for the external convert pin
module sarc_sync
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic d,
   output logic      q
);
   logic meta_r;
   logic q_r;

   // First stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_r <= 1'b0;
         q_r    <= 1'b0;
      end
      else
      begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end
   assign q = q_r;
endmodule : sarc_sync
`default_nettype wire

// file: sarc_search.sv
`timescale 1ns/1ns
`default_nettype none
// Successive approximation register: one bit per step, MSB first
module sarc_search
   import sarc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                start,
   input  wire logic                cmp_high,
   output logic [RES_BITS-1:0]      trial,
   output logic                     done,
   output logic [RES_BITS-1:0]      code
);
   logic [RES_BITS-1:0] code_r, code_nxt;
   logic [RES_BITS-1:0] bit_r, bit_nxt;
   logic                done_r, done_nxt;
   logic [RES_BITS-1:0] trial_r, trial_nxt;

   // Keep or drop the trial bit, then move to the next lower one
   always_comb
   begin
      code_nxt = code_r;
      bit_nxt  = bit_r;
      done_nxt = 1'b0;
      if (start)
      begin
         code_nxt = '0;
         bit_nxt  = {1'b1, {(RES_BITS-1){1'b0}}}; // R16
      end
      else if (bit_r != '0)
      begin
         code_nxt = cmp_high ? (code_r | bit_r) : code_r; // R16
         bit_nxt  = bit_r >> 1;
         done_nxt = (bit_r == {{(RES_BITS-1){1'b0}}, 1'b1}); // R07
      end
      // Trial is registered here so the DAC shows the bit under test, not the one before
      trial_nxt = code_nxt | bit_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         code_r <= '0;
         bit_r  <= '0;
         done_r <= 1'b0;
         trial_r <= '0;
      end
      else
      begin
         code_r <= code_nxt;
         bit_r  <= bit_nxt;
         done_r <= done_nxt;
         trial_r <= trial_nxt;
      end
   end

   assign trial = trial_r;
   assign done  = done_r;
   assign code  = code_r;
endmodule : sarc_search
`default_nettype wire

// file: tb_sar_adc_result_and_reference_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the converter control block, driven over its register port
module tb_sar_adc_result_and_reference_ctrl;
   import sarc_pkg::*;

   logic        clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        cmp_high;
   logic [11:0] dac_trial;
   logic        bal_sw;
   logic        pos_sw;
   logic [1:0]  neg_sw;
   logic [4:0]  pos_chan;
   logic [4:0]  neg_chan;
   logic        temp_sel;
   logic        powered;
   logic        ref_en;
   logic        dac_en;
   logic        irq;
   logic [11:0] target;
   int          err_total;
   int          check_count;
   logic [31:0] d;
   logic        conv_pin;
   int          n_poll;
   // Power-up settling of 5 us at the 10 ns clock
   localparam int POWER_UP_CYCLES = 500;

   // Clock at 100 MHz
   always #5 clk = ~clk;

   // Ideal comparator: keep the trial bit while the trial does not exceed the input
   assign cmp_high = (dac_trial <= target);

   sarc_ctrl i_sarc_ctrl (
      .clk                       (clk),
      .sys_rst                   (sys_rst),
      .reg_addr                  (reg_addr),
      .reg_wdata                 (reg_wdata),
      .reg_wr                    (reg_wr),
      .reg_rd                    (reg_rd),
      .reg_rdata                 (reg_rdata),
      .external_convert_pin      (conv_pin),
      .timer_trigger             (1'b0),
      .cmp_high                  (cmp_high),
      .dac_trial                 (dac_trial),
      .comparator_balance_switch (bal_sw),
      .positive_input_switch     (pos_sw),
      .negative_input_switch     (neg_sw),
      .mux_pos_chan              (pos_chan),
      .mux_neg_chan              (neg_chan),
      .temp_sensor_sel           (temp_sel),
      .adc_powered               (powered),
      .ref_pin_enable            (ref_en),
      .dac_enable                (dac_en),
      .irq                       (irq)
   );

   // Single place where the run ends
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One-cycle write strobe, released at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data only stand in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   // Single software conversion; 2'h3 in neg_conv means the conversion position is not checked
   task automatic convert(input logic [1:0] mode, input logic [11:0] value,
                          input logic [1:0] neg_acq, input logic [1:0] neg_conv);
      int n;
      logic [31:0] v;
      target = value;
      wr(OFF_CONTROL, 32'(8'hA3 | {3'h0, mode, 3'h0}));
      repeat (3) @(posedge clk);
      #1;
      chk("balance_acq", 32'(bal_sw), 32'h1);
      chk("pos_sw_acq", 32'(pos_sw), 32'h0);
      chk("neg_sw_acq", 32'(neg_sw), 32'(neg_acq));
      rd(OFF_STATUS, v);
      chk("status_busy", v & 32'h1, 32'h0);
      n = 0;
      while (bal_sw !== 1'b0 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("balance_conv", 32'(bal_sw), 32'h0);
      chk("pos_sw_conv", 32'(pos_sw), 32'h1);
      if (neg_conv != 2'h3)
         chk("neg_sw_conv", 32'(neg_sw), 32'(neg_conv));
      n = 0;
      v = 32'h0;
      while (v[0] !== 1'b1 && n < 30)
      begin
         rd(OFF_STATUS, v);
         n++;
      end
      chk("status_done", v & 32'h1, 32'h1);
      rd(OFF_RESULT, v);
      chk("result", 32'(v[27:16]), 32'(value));
      chk("result_unused", v & 32'hF000FFFF, 32'h0);
      rd(OFF_STATUS, v);
      chk("status_cleared", v & 32'h1, 32'h0);
      rd(OFF_CONTROL, v);
      chk("type_cleared", v, 32'(8'hA0 | {3'h0, mode, 3'h0}));
   endtask : convert

   // Watchdog well beyond the expected run of about a thousand cycles
   initial
   begin
      #200000;
      err_total++;
      $display("MISMATCH watchdog expected finish seen timeout");
      report_and_stop();
   end

   logic [7:0]  offs  [6] = '{OFF_CONTROL, OFF_POS_CHAN, OFF_NEG_CHAN, OFF_STATUS, OFF_REF_CTRL, OFF_IRQ_MASK};
   logic [1:0]  modes [4] = '{MODE_SINGLE, MODE_DIFF, MODE_PSEUDO, 2'h3};
   logic [11:0] vals  [4] = '{12'hA5A, 12'hFFF, 12'h000, 12'h001};
   logic [1:0]  nacq  [4] = '{2'h1, 2'h0, 2'h0, 2'h1};
   logic [1:0]  nconv [4] = '{2'h1, 2'h3, 2'h2, 2'h1};

   // Main sequence
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      target = 12'h000;
      conv_pin = 1'b0;
      err_total = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk("balance_rst", 32'(bal_sw), 32'h1);
      chk("neg_sw_rst", 32'(neg_sw), 32'h1);
      chk("irq_rst", 32'(irq), 32'h0);
      foreach (offs[i])
      begin
         rd(offs[i], d);
         chk("reset_value", d, 32'h0);
      end
      // Power up, select the temperature channel and drive the reference pin
      wr(OFF_CONTROL, 32'h20);
      wr(OFF_POS_CHAN, 32'h10);
      wr(OFF_REF_CTRL, 32'h01);
      #1;
      chk("powered", 32'(powered), 32'h1);
      chk("temp_sel", 32'(temp_sel), 32'h1);
      chk("pos_chan", 32'(pos_chan), 32'h10);
      chk("ref_pin", 32'(ref_en), 32'h1);
      @(posedge clk);
      #1;
      chk("dac_on", 32'(dac_en), 32'h1);
      rd(OFF_REF_CTRL, d);
      chk("ref_readback", d & 32'h1, 32'h1);
      wr(OFF_POS_CHAN, 32'h03);
      wr(OFF_NEG_CHAN, 32'h05);
      #1;
      chk("temp_sel_off", 32'(temp_sel), 32'h0);
      chk("neg_chan", 32'(neg_chan), 32'h05);
      wr(OFF_IRQ_MASK, 32'h1);
      repeat (POWER_UP_CYCLES) @(posedge clk);
      #1;
      // Every mode, with extreme codes to expose bit order faults
      foreach (modes[i])
         convert(modes[i], vals[i], nacq[i], nconv[i]);
      chk("irq_set", 32'(irq), 32'h1);
      rd(OFF_IRQ_STAT, d);
      chk("irq_stat", d & 32'h1, 32'h1);
      wr(OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk("irq_clear", 32'(irq), 32'h0);
      // Masked event stays silent until the mask opens
      wr(OFF_IRQ_MASK, 32'h0);
      convert(MODE_SINGLE, 12'h3C7, 2'h1, 2'h1);
      chk("irq_masked", 32'(irq), 32'h0);
      wr(OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk("irq_unmasked", 32'(irq), 32'h1);
      wr(OFF_IRQ_STAT, 32'h1);
      // Read-only places ignore writes, unmapped reads give zero
      wr(OFF_STATUS, 32'hFF);
      rd(OFF_STATUS, d);
      chk("status_ro", d, 32'h0);
      rd(8'h40, d);
      chk("unmapped", d, 32'h0);
      // Reference off stops the DAC
      wr(OFF_REF_CTRL, 32'h00);
      repeat (2) @(posedge clk);
      #1;
      chk("ref_pin_off", 32'(ref_en), 32'h0);
      chk("dac_off", 32'(dac_en), 32'h0);
      // A rising edge on the convert pin starts one conversion
      target = 12'h2D4;
      wr(OFF_CONTROL, 32'hA0);
      conv_pin <= 1'b1;
      repeat (60) @(posedge clk);
      conv_pin <= 1'b0;
      rd(OFF_STATUS, d);
      chk("pin_done", d & 32'h1, 32'h1);
      rd(OFF_RESULT, d);
      chk("pin_result", 32'(d[27:16]), 32'h2D4);
      // Continuous conversions set the flag again after each result read
      target = 12'h525;
      wr(OFF_CONTROL, 32'hE4);
      repeat (2)
      begin
         n_poll = 0;
         d = 32'h0;
         while (d[0] !== 1'b1 && n_poll < 60)
         begin
            rd(OFF_STATUS, d);
            n_poll++;
         end
         chk("cont_done", d & 32'h1, 32'h1);
         rd(OFF_RESULT, d);
         chk("cont_result", 32'(d[27:16]), 32'h525);
      end
      // Soft reset returns every register to its default
      wr(OFF_REF_CTRL, 32'h01);
      wr(OFF_SOFT_RST, 32'h1);
      repeat (2) @(posedge clk);
      foreach (offs[i])
      begin
         rd(offs[i], d);
         chk("soft_reset", d, 32'h0);
      end
      chk("ref_pin_soft", 32'(ref_en), 32'h0);
      report_and_stop();
   end
endmodule : tb_sar_adc_result_and_reference_ctrl
`default_nettype wire
